// ===== inc/cxe_pkg.sv
// constants for the exception entry unit
package cxe_pkg;
    // ------------------------------------------------------------
    // configuration word fields
    // ------------------------------------------------------------
    localparam int          CFG_ADDR_FAULT_BIT  = 31;
    localparam int          CFG_INSTR_FAULT_BIT = 30;
    localparam int          CFG_ACK_READ_BIT    = 29;
    localparam int          CFG_POSTED_BIT      = 27;
    localparam int          CFG_FLASH_SPEC_BIT  = 25;
    localparam logic [31:0] CFG_WRITE_MASK      = 32'hea00_0000;
    localparam logic [31:0] CFG_RESET           = 32'h0000_0000;
    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int          SW_TRACE_BIT  = 15;
    localparam int          SW_SUPER_BIT  = 13;
    localparam int          SW_MASTER_BIT = 12;
    localparam int          SW_MASK_LSB   = 8;
    localparam logic [15:0] SW_RESET      = 16'h2700;
    localparam logic [15:0] SW_WRITE_MASK = 16'hb71f;
    // ------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------
    localparam logic [7:0] VEC_ACCESS   = 8'h02;
    localparam logic [7:0] VEC_ADDRESS  = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL  = 8'h04;
    localparam logic [7:0] VEC_DIVZERO  = 8'h05;
    localparam logic [7:0] VEC_PRIV     = 8'h08;
    localparam logic [7:0] VEC_TRACE    = 8'h09;
    localparam logic [7:0] VEC_LINE_A   = 8'h0a;
    localparam logic [7:0] VEC_LINE_F   = 8'h0b;
    localparam logic [7:0] VEC_DEBUG    = 8'h0c;
    localparam logic [7:0] VEC_FORMAT   = 8'h0e;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] VEC_TRAP0    = 8'h20;
    localparam logic [7:0] VEC_SWI_L7   = 8'h60;
    localparam logic [7:0] VEC_LAST     = 8'h66;
    localparam logic [31:0] VBASE_MASK  = 32'h00f0_0000;
    // ------------------------------------------------------------
    // frame and fault status
    // ------------------------------------------------------------
    localparam logic [3:0] FMT_BASE     = 4'h4;
    localparam logic [3:0] FS_NONE      = 4'h0;
    localparam logic [3:0] FS_FETCH     = 4'h4;
    localparam logic [3:0] FS_WRITE     = 4'h8;
    localparam logic [3:0] FS_PROTECT   = 4'h9;
    localparam logic [3:0] FS_READ      = 4'hc;
    localparam logic [31:0] ACK_BASE    = 32'hffff_ffe0;
    // ------------------------------------------------------------
    // exception kinds and states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        EX_ACCESS, EX_ADDRESS, EX_ILLEGAL, EX_ILLEGAL_OP, EX_DIVZERO, EX_PRIV,
        EX_TRACE, EX_LINE_A, EX_LINE_F, EX_DEBUG, EX_FORMAT, EX_SPURIOUS,
        EX_TRAP, EX_IRQ, EX_FAULT_ON_FAULT
    } cxe_kind_e;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ACK, ST_PUSH0, ST_PUSH1, ST_VEC, ST_FETCH, ST_FIRST
    } cxe_state_e;
endpackage : cxe_pkg

// ===== logic/cxe_entry.sv
// exception entry sequencer with configuration word and status word
`timescale 1ns/1ps
// How it works
// [RL1] bit 31 turns address faults into exceptions
// [RL2] bit 30 turns instruction faults into exceptions
// [RL3] bit 29 fetches vector by acknowledge read
// [RL4] bit 27 disables posted peripheral writes
// [RL5] bit 25 disables flash read speculation
// [RL6] entry copies status, sets supervisor, clears trace
// [RL7] fault vector from kind; ack address encodes level
// [RL8] two-longword frame at word-aligned stack
// [RL9] handler read at base plus four times vector
// [RL10] entry ends when handler fetch issued; code stays busy until the first handler instruction retires
// [RL11] only vectors 0 to 102 used; code does not limit vectors from the pins or the acknowledge read
// [RL12] fault vectors 2,3,4,5,8,10,11,14
// [RL13] trace 9, debug 12, spurious 24, traps, swi; code generates no swi vector
// [RL14] stacked pc: faulting or next instruction
// [RL15] no interrupt sampling during first handler instruction
// [RL16] store-and-load-status saves mask, loads status
// [RL17] frame: format/vector, status, then pc
// [RL18] format field 4 to 7 from misalignment
// [RL19] fault status only for access/address errors
// [RL20] fault status codes 4, 8, 9, 12
// [RL21] vector number computed or from controller
module cxe_entry (
    input  wire logic        clk,            // core clock
    input  wire logic        rst_n,          // synchronous reset
    input  wire logic        ce,             // clock enable
    input  wire logic        cfg_we,         // config word write
    input  wire logic [31:0] cfg_wdata,      // config word data
    output logic      [31:0] core_config_word, // config word readback
    output logic             addr_fault_reset_off,  // config bit 31
    output logic             instr_fault_reset_off, // config bit 30
    output logic             ack_read_enable,       // config bit 29
    output logic             posted_write_off,      // config bit 27
    output logic             flash_spec_off,        // config bit 25
    input  wire logic        sw_we,          // status word write
    input  wire logic [15:0] sw_wdata,       // status word data
    input  wire logic        sl_exec,        // store-and-load-status strobe
    input  wire logic [15:0] sl_imm,         // value it loads
    output logic      [2:0]  sl_saved_mask,  // mask it saved
    output logic      [15:0] processor_status_word, // status word
    input  wire logic        vbase_we,       // vector base write
    input  wire logic [31:0] vbase_wdata,    // vector base data
    output logic      [31:0] vector_base,    // vector base
    input  wire logic [31:0] supervisor_stack_ptr, // stack before entry
    output logic      [31:0] new_stack_ptr,  // stack after frame
    output logic             new_sp_valid,   // pulse with new_stack_ptr
    input  wire logic        exc_req,        // fault or trap request
    input  wire cxe_pkg::cxe_kind_e exc_kind, // its kind
    input  wire logic [3:0]  exc_trap_num,   // trap number
    input  wire logic [3:0]  exc_fs,         // fault status code
    input  wire logic [31:0] exc_pc_fault,   // pc of faulting instr
    input  wire logic [31:0] exc_pc_next,    // pc of next instr
    input  wire logic        irq_req,        // interrupt request, pin
    input  wire logic [2:0]  irq_level,      // its level, pin
    input  wire logic [7:0]  irq_vector,     // its vector, pin
    output logic             exc_busy,       // entry in progress
    output logic             reset_event,    // pulse: fault becomes reset
    output logic             mem_req,        // bus request
    output logic             mem_we,         // bus write
    output logic      [31:0] mem_addr,       // bus address
    output logic      [31:0] mem_wdata,      // bus write data
    input  wire logic        mem_ack,        // bus done
    input  wire logic [31:0] mem_rdata,      // bus read data
    output logic             fetch_req,      // pulse: handler fetch
    output logic      [31:0] fetch_addr,     // handler address
    input  wire logic        instr_done      // pulse: instr retired
);
    // ------------------------------------------------------------
    // pin synchronisers for the interrupt request group
    // ------------------------------------------------------------
    logic [11:0] irq_s1_q, irq_s2_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_s1_q <= 12'h000;
            irq_s2_q <= 12'h000;
        end
        else if (ce)
        begin
            irq_s1_q <= {irq_req, irq_level, irq_vector};
            irq_s2_q <= irq_s1_q;
        end
    end
    wire       irq_s   = irq_s2_q[11];
    wire [2:0] irql_s  = irq_s2_q[10:8];
    wire [7:0] irqv_s  = irq_s2_q[7:0];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cxe_pkg::cxe_state_e st_q, st_d;
    logic [31:0] cfg_q, cfg_d, vb_q, vb_d, sp_q, sp_d, pc_q, pc_d, ha_q, ha_d;
    logic [15:0] sw_q, sw_d, swc_q, swc_d;
    logic [7:0]  vec_q, vec_d;
    logic [3:0]  fs_q, fs_d;
    logic [1:0]  mis_q, mis_d;
    logic [2:0]  lvl_q, lvl_d, slm_q, slm_d;
    logic        rst_ev_q, rst_ev_d, nsv_q, nsv_d, fr_q, fr_d;

    wire irq_take = irq_s && ((irql_s == 3'd7) ||
                    (irql_s > sw_q[cxe_pkg::SW_MASK_LSB +: 3]));

    // fault-class kinds that may instead raise a reset event
    function automatic logic goes_reset(input cxe_pkg::cxe_kind_e k,
                                        input logic [31:0] c);
        case (k)
            cxe_pkg::EX_ACCESS, cxe_pkg::EX_ADDRESS, cxe_pkg::EX_FORMAT,
            cxe_pkg::EX_FAULT_ON_FAULT:
                goes_reset = !c[cxe_pkg::CFG_ADDR_FAULT_BIT]; // RL1
            cxe_pkg::EX_ILLEGAL, cxe_pkg::EX_LINE_A, cxe_pkg::EX_LINE_F,
            cxe_pkg::EX_PRIV:
                goes_reset = !c[cxe_pkg::CFG_INSTR_FAULT_BIT]; // RL2
            default:
                goes_reset = 1'b0;
        endcase
    endfunction : goes_reset

    function automatic logic [7:0] kind_vec(input cxe_pkg::cxe_kind_e k,
                                            input logic [3:0] t);
        case (k) // RL7
            cxe_pkg::EX_ACCESS:     kind_vec = cxe_pkg::VEC_ACCESS; // RL12
            cxe_pkg::EX_ADDRESS:    kind_vec = cxe_pkg::VEC_ADDRESS;
            cxe_pkg::EX_ILLEGAL, cxe_pkg::EX_ILLEGAL_OP:
                                    kind_vec = cxe_pkg::VEC_ILLEGAL;
            cxe_pkg::EX_DIVZERO:    kind_vec = cxe_pkg::VEC_DIVZERO;
            cxe_pkg::EX_PRIV:       kind_vec = cxe_pkg::VEC_PRIV;
            cxe_pkg::EX_LINE_A:     kind_vec = cxe_pkg::VEC_LINE_A;
            cxe_pkg::EX_LINE_F:     kind_vec = cxe_pkg::VEC_LINE_F;
            cxe_pkg::EX_FORMAT:     kind_vec = cxe_pkg::VEC_FORMAT;
            cxe_pkg::EX_TRACE:      kind_vec = cxe_pkg::VEC_TRACE; // RL13
            cxe_pkg::EX_DEBUG:      kind_vec = cxe_pkg::VEC_DEBUG;
            cxe_pkg::EX_SPURIOUS:   kind_vec = cxe_pkg::VEC_SPURIOUS;
            cxe_pkg::EX_TRAP:       kind_vec = cxe_pkg::VEC_TRAP0 + {4'h0, t};
            default:                kind_vec = cxe_pkg::VEC_SPURIOUS;
        endcase
    endfunction : kind_vec

    function automatic logic is_fault_pc(input cxe_pkg::cxe_kind_e k);
        case (k) // RL14
            cxe_pkg::EX_TRACE, cxe_pkg::EX_DEBUG, cxe_pkg::EX_SPURIOUS,
            cxe_pkg::EX_TRAP, cxe_pkg::EX_IRQ:
                is_fault_pc = 1'b0;
            default:
                is_fault_pc = 1'b1;
        endcase
    endfunction : is_fault_pc

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q; cfg_d = cfg_q; vb_d = vb_q; sp_d = sp_q; pc_d = pc_q;
        ha_d = ha_q; sw_d = sw_q; swc_d = swc_q; vec_d = vec_q; fs_d = fs_q;
        mis_d = mis_q; lvl_d = lvl_q; slm_d = slm_q;
        rst_ev_d = 1'b0; nsv_d = 1'b0; fr_d = 1'b0;
        if (cfg_we)
            cfg_d = cfg_wdata & cxe_pkg::CFG_WRITE_MASK; // RL4 RL5
        if (vbase_we)
            vb_d = vbase_wdata & cxe_pkg::VBASE_MASK; // RL9
        if (sw_we)
            sw_d = sw_wdata & cxe_pkg::SW_WRITE_MASK;
        if (sl_exec)
        begin
            slm_d = sw_q[cxe_pkg::SW_MASK_LSB +: 3]; // RL16
            sw_d  = sl_imm & cxe_pkg::SW_WRITE_MASK;
        end
        case (st_q)
            cxe_pkg::ST_IDLE:
            begin
                if (exc_req || irq_take)
                begin
                    sp_d  = supervisor_stack_ptr;
                    mis_d = supervisor_stack_ptr[1:0];
                    if (exc_req && goes_reset(exc_kind, cfg_q))
                        rst_ev_d = 1'b1;
                    else
                    begin
                        swc_d = sw_q; // RL6
                        sw_d[cxe_pkg::SW_SUPER_BIT] = 1'b1;
                        sw_d[cxe_pkg::SW_TRACE_BIT] = 1'b0;
                        if (exc_req)
                        begin
                            vec_d = kind_vec(exc_kind, exc_trap_num);
                            pc_d  = is_fault_pc(exc_kind) ? exc_pc_fault
                                                          : exc_pc_next;
                            fs_d  = (exc_kind == cxe_pkg::EX_ACCESS ||
                                     exc_kind == cxe_pkg::EX_ADDRESS)
                                    ? exc_fs : cxe_pkg::FS_NONE; // RL19 RL20
                            st_d  = cxe_pkg::ST_PUSH0;
                        end
                        else
                        begin
                            sw_d[cxe_pkg::SW_MASTER_BIT] = 1'b0;
                            sw_d[cxe_pkg::SW_MASK_LSB +: 3] = irql_s;
                            lvl_d = irql_s;
                            vec_d = irqv_s; // RL21
                            pc_d  = exc_pc_next;
                            fs_d  = cxe_pkg::FS_NONE;
                            st_d  = cfg_q[cxe_pkg::CFG_ACK_READ_BIT]
                                    ? cxe_pkg::ST_ACK : cxe_pkg::ST_PUSH0; // RL3
                        end
                    end
                end
            end
            cxe_pkg::ST_ACK:
                if (mem_ack)
                begin
                    vec_d = mem_rdata[7:0]; // RL21
                    st_d  = cxe_pkg::ST_PUSH0;
                end
            cxe_pkg::ST_PUSH0:
                if (mem_ack)
                    st_d = cxe_pkg::ST_PUSH1;
            cxe_pkg::ST_PUSH1:
                if (mem_ack)
                begin
                    nsv_d = 1'b1;
                    st_d  = cxe_pkg::ST_VEC;
                end
            cxe_pkg::ST_VEC:
                if (mem_ack)
                begin
                    ha_d = mem_rdata;
                    st_d = cxe_pkg::ST_FETCH;
                end
            cxe_pkg::ST_FETCH:
            begin
                fr_d = 1'b1; // RL10
                st_d = cxe_pkg::ST_FIRST;
            end
            cxe_pkg::ST_FIRST:
                if (instr_done)
                    st_d = cxe_pkg::ST_IDLE; // RL15
            default:
                st_d = cxe_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= cxe_pkg::ST_IDLE; cfg_q <= cxe_pkg::CFG_RESET;
            vb_q <= 32'h0000_0000; sp_q <= 32'h0000_0000; pc_q <= 32'h0000_0000;
            ha_q <= 32'h0000_0000; sw_q <= cxe_pkg::SW_RESET;
            swc_q <= cxe_pkg::SW_RESET; vec_q <= 8'h00; fs_q <= 4'h0;
            mis_q <= 2'h0; lvl_q <= 3'h0; slm_q <= 3'h0;
            rst_ev_q <= 1'b0; nsv_q <= 1'b0; fr_q <= 1'b0;
        end
        else if (ce)
        begin
            st_q <= st_d; cfg_q <= cfg_d; vb_q <= vb_d; sp_q <= sp_d;
            pc_q <= pc_d; ha_q <= ha_d; sw_q <= sw_d; swc_q <= swc_d;
            vec_q <= vec_d; fs_q <= fs_d; mis_q <= mis_d; lvl_q <= lvl_d;
            slm_q <= slm_d; rst_ev_q <= rst_ev_d; nsv_q <= nsv_d; fr_q <= fr_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // frame base: word-aligned below stack, 8 bytes long
    wire [31:0] frame_base = {sp_q[31:2], 2'b00} - 32'd8; // RL8
    wire [15:0] fv_word = {cxe_pkg::FMT_BASE | {2'b00, mis_q}, // RL18
                           fs_q[3:2], vec_q, fs_q[1:0]};
    always_comb
    begin
        mem_req = 1'b0; mem_we = 1'b0; mem_addr = 32'h0000_0000;
        mem_wdata = 32'h0000_0000;
        case (st_q)
            cxe_pkg::ST_ACK:
            begin
                mem_req  = 1'b1;
                mem_addr = cxe_pkg::ACK_BASE | {27'h0, lvl_q, 2'b00}; // RL7
            end
            cxe_pkg::ST_PUSH0:
            begin
                mem_req = 1'b1; mem_we = 1'b1; mem_addr = frame_base;
                mem_wdata = {fv_word, swc_q}; // RL17
            end
            cxe_pkg::ST_PUSH1:
            begin
                mem_req = 1'b1; mem_we = 1'b1; mem_addr = frame_base + 32'd4;
                mem_wdata = pc_q;
            end
            cxe_pkg::ST_VEC:
            begin
                mem_req  = 1'b1;
                mem_addr = vb_q | {22'h0, vec_q, 2'b00}; // RL9 RL11
            end
            default: ;
        endcase
    end
    assign core_config_word      = cfg_q;
    assign addr_fault_reset_off  = cfg_q[cxe_pkg::CFG_ADDR_FAULT_BIT];
    assign instr_fault_reset_off = cfg_q[cxe_pkg::CFG_INSTR_FAULT_BIT];
    assign ack_read_enable       = cfg_q[cxe_pkg::CFG_ACK_READ_BIT];
    assign posted_write_off      = cfg_q[cxe_pkg::CFG_POSTED_BIT];
    assign flash_spec_off        = cfg_q[cxe_pkg::CFG_FLASH_SPEC_BIT];
    assign processor_status_word = sw_q;
    assign sl_saved_mask         = slm_q;
    assign vector_base           = vb_q;
    assign new_stack_ptr         = frame_base;
    assign new_sp_valid          = nsv_q;
    assign exc_busy              = (st_q != cxe_pkg::ST_IDLE);
    assign reset_event           = rst_ev_q;
    assign fetch_req             = fr_q;
    assign fetch_addr            = ha_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_push_done;
        st_q == cxe_pkg::ST_PUSH1 && mem_ack && ce;
    endsequence
    a_cfg_reset_path: assert property (@(posedge clk) disable iff (!rst_n) // RL1
        (ce && st_q == cxe_pkg::ST_IDLE && exc_req &&
         exc_kind == cxe_pkg::EX_ADDRESS && !cfg_q[31]) |=> reset_event)
        else $error("address fault did not raise reset");
    a_instr_fault_exc: assert property (@(posedge clk) disable iff (!rst_n) // RL2
        (ce && st_q == cxe_pkg::ST_IDLE && exc_req &&
         exc_kind == cxe_pkg::EX_PRIV && cfg_q[30]) |=> !reset_event && exc_busy)
        else $error("privilege fault not taken as exception");
    a_ack_read_addr: assert property (@(posedge clk) disable iff (!rst_n) // RL3
        st_q == cxe_pkg::ST_ACK |-> mem_req && !mem_we && cfg_q[29]
            && mem_addr[4:2] == lvl_q)
        else $error("acknowledge read wrong");
    a_frame_aligned: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        mem_we |-> mem_addr[1:0] == 2'b00)
        else $error("frame not word aligned");
    a_entry_status: assert property (@(posedge clk) disable iff (!rst_n) // RL6
        st_q == cxe_pkg::ST_PUSH0 |-> sw_q[13] && !sw_q[15])
        else $error("status not in supervisor on entry");
    a_format_field: assert property (@(posedge clk) disable iff (!rst_n) // RL18
        st_q == cxe_pkg::ST_PUSH0 |-> mem_wdata[31:28] == {2'b01, mis_q})
        else $error("format field wrong");
    a_handler_fetch: assert property (@(posedge clk) disable iff (!rst_n) // RL10
        st_q == cxe_pkg::ST_VEC && mem_ack && ce |=> ##1 fetch_req)
        else $error("handler fetch not issued");
    a_sp_flag: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        s_push_done |=> new_sp_valid)
        else $error("stack pointer not flagged");
    a_vec_addr: assert property (@(posedge clk) disable iff (!rst_n) // RL9
        st_q == cxe_pkg::ST_VEC |-> mem_addr == vb_q + {22'h0, vec_q, 2'b00})
        else $error("vector table address wrong");
    a_no_irq_first: assert property (@(posedge clk) disable iff (!rst_n) // RL15
        st_q == cxe_pkg::ST_FIRST && !instr_done && ce |=> exc_busy)
        else $error("left first instruction early");
endmodule : cxe_entry

// ===== testbench/cxe_intc_model.sv
// bus responder standing in for the interrupt controller and memory
`timescale 1ns/1ps
module cxe_intc_model #(
    parameter logic [7:0] ACK_VEC = 8'h41  // vector handed back on acknowledge
) (
    input  wire logic        clk,       // core clock
    input  wire logic        slow,      // stretch each answer by three cycles
    input  wire logic        mem_req,   // bus request
    input  wire logic        mem_we,    // bus write
    input  wire logic [31:0] mem_addr,  // bus address
    input  wire logic [31:0] mem_wdata, // bus write data
    output logic             mem_ack,   // bus done
    output logic      [31:0] mem_rdata  // bus read data
);
    logic [31:0] log_addr [256];
    logic [31:0] log_data [256];
    int          n = 0;
    int          w = 0;
    initial {mem_ack, mem_rdata} = '0;
    always @(posedge clk)
    begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;  // no stale value lingers between answers
        if (mem_req && !mem_ack && w < (slow ? 3 : 0))
            w <= w + 1;
        else if (mem_req && !mem_ack)
        begin
            w                <= 0;
            mem_ack          <= 1'b1;
            log_addr[n[7:0]] <= mem_addr;
            log_data[n[7:0]] <= mem_we ? mem_wdata : 32'h0;
            n                <= n + 1;
            if (mem_addr[31:5] == 27'h7ffffff)
                mem_rdata <= {4{ACK_VEC}};
            else
                mem_rdata <= 32'h0000_4000 | {20'h0, mem_addr[11:0]};
        end
    end
endmodule : cxe_intc_model

// ===== testbench/testbench.sv
// self-checking bench for the exception entry unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
    logic        clk, rst_n, cfg_we, sw_we, sl_exec, vbase_we, exc_req, irq_req;
    logic        instr_done, slow, mem_ack, mem_req, mem_we, new_sp_valid, exc_busy;
    logic        reset_event, fetch_req;
    logic [31:0] cfg_wdata, vbase_wdata, core_config_word, vector_base, supervisor_stack_ptr;
    logic [31:0] new_stack_ptr, exc_pc_fault, exc_pc_next, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] fetch_addr;
    logic [15:0] sw_wdata, sl_imm, processor_status_word;
    logic [7:0]  irq_vector;
    logic [4:0]  cb;
    logic [3:0]  exc_trap_num, exc_fs;
    logic [2:0]  sl_saved_mask, irq_level;
    cxe_pkg::cxe_kind_e exc_kind;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [7:0]  vt [15] = '{8'h02, 8'h03, 8'h04, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0a, 8'h0b,
                             8'h0c, 8'h0e, 8'h18, 8'h2f, 8'h00, 8'h00};
    logic [3:0]  fsc [4] = '{4'h4, 4'h8, 4'h9, 4'hc};
    cxe_entry i_cxe_entry (.clk, .rst_n, .ce(1'b1), .cfg_we, .cfg_wdata, .core_config_word,
        .addr_fault_reset_off(cb[4]), .instr_fault_reset_off(cb[3]), .ack_read_enable(cb[2]),
        .posted_write_off(cb[1]), .flash_spec_off(cb[0]), .sw_we, .sw_wdata, .sl_exec, .sl_imm,
        .sl_saved_mask, .processor_status_word, .vbase_we, .vbase_wdata, .vector_base,
        .supervisor_stack_ptr, .new_stack_ptr, .new_sp_valid, .exc_req, .exc_kind,
        .exc_trap_num, .exc_fs, .exc_pc_fault, .exc_pc_next, .irq_req, .irq_level, .irq_vector,
        .exc_busy, .reset_event, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata, .fetch_req, .fetch_addr, .instr_done);
    cxe_intc_model i_cxe_intc_model (.clk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_ack, .mem_rdata);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    // k: 0 config, 1 status, 2 vector base, 3 store-and-load-status
    task automatic wr(input int k, input logic [31:0] d);
        @(posedge clk);
        {cfg_we, sw_we, vbase_we, sl_exec} <= 4'h8 >> k;
        {cfg_wdata, vbase_wdata} <= {d, d};
        {sw_wdata, sl_imm} <= {d[15:0], d[15:0]};
        @(posedge clk);
        {cfg_we, sw_we, vbase_we, sl_exec} <= 4'h0;
        #1;
    endtask : wr
    task automatic entry(input int b, output logic [31:0] fa, output logic [31:0] la [4],
                         output logic [31:0] ld [4]);
        int i;
        for (i = 0; i < 200 && fetch_req !== 1'b1; i++)
            @(posedge clk);
        fa = fetch_addr;
        `CHK("fetch seen", 1'b1, fetch_req)
        irq_req <= 1'b0;
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("busy after", 1'b0, exc_busy)
        for (i = 0; i < 4; i++)
        begin
            la[i] = i_cxe_intc_model.log_addr[b + i];
            ld[i] = i_cxe_intc_model.log_data[b + i];
        end
    endtask : entry
    task automatic fault(input int k, input logic [31:0] c, input logic [31:0] sp,
                         input logic [3:0] code);
        logic [31:0] fa, fw;
        logic [31:0] la [4];
        logic [31:0] ld [4];
        logic [3:0]  fs;
        logic        rs;
        logic        hit;
        logic        bsy;
        int          b;
        rs = (!c[31] && k inside {0, 1, 10, 14}) || (!c[30] && k inside {2, 5, 7, 8});
        fs = (k < 2) ? code : 4'h0;
        fw = {2'b01, sp[1:0], fs[3:2], vt[k], fs[1:0], 16'h8700};
        b = i_cxe_intc_model.n;
        {hit, bsy} = 2'b00;
        @(posedge clk);
        supervisor_stack_ptr <= sp;
        exc_fs <= code;
        slow <= k[0];
        exc_kind <= cxe_pkg::cxe_kind_e'(k);
        exc_req <= 1'b1;
        @(posedge clk);
        exc_req <= 1'b0;
        repeat (3)
        begin
            @(posedge clk);
            {hit, bsy} = {hit | reset_event, bsy | exc_busy};
        end
        `CHK("reset_event", rs, hit)
        `CHK("entered", !rs, bsy)
        if (!rs)
        begin
            entry(b, fa, la, ld);
            `CHK("fetch_addr", 32'h4000 | {22'h0, vt[k], 2'b00}, fa)
            `CHK("vector read", 32'h0030_0000 | {22'h0, vt[k], 2'b00}, la[2])
            `CHK("frame word", fw, ld[0])
            `CHK("frame addr", {sp[31:2], 2'b00} - 32'h8, la[0])
            `CHK("new sp", {sp[31:2], 2'b00} - 32'h8, new_stack_ptr)
            `CHK("frame pc", (k inside {6, 9, 11, 12}) ? exc_pc_next : exc_pc_fault, ld[1])
            `CHK("status", 16'h2700, processor_status_word)
        end
    endtask : fault
    task automatic irq(input logic ack);
        logic [31:0] fa;
        logic [31:0] la [4];
        logic [31:0] ld [4];
        logic [7:0]  v;
        int          a;
        wr(0, {2'b11, ack, 29'h0});
        wr(1, 32'h1000);
        v = ack ? 8'h41 : 8'h55;
        a = ack ? 1 : 0;
        @(posedge clk);
        supervisor_stack_ptr <= 32'h3000;
        {irq_level, irq_vector, irq_req} <= {3'd3, 8'h55, 1'b1};
        entry(i_cxe_intc_model.n, fa, la, ld);
        `CHK("first access", ack ? 32'hffff_ffec : 32'h0000_2ff8, la[0])
        `CHK("frame word", {4'h4, 2'b00, v, 2'b00, 16'h1000}, ld[a])
        `CHK("frame pc", exc_pc_next, ld[a + 1])
        `CHK("status", 16'h2300, processor_status_word)
        `CHK("fetch_addr", 32'h4000 | {22'h0, v, 2'b00}, fa)
    endtask : irq
    initial
    begin
        {rst_n, cfg_we, sw_we, sl_exec, vbase_we, exc_req, irq_req, instr_done, slow} = '0;
        {cfg_wdata, vbase_wdata, supervisor_stack_ptr} = '0;
        {sw_wdata, sl_imm, irq_vector, exc_fs, irq_level} = '0;
        exc_kind = cxe_pkg::EX_ACCESS;
        exc_trap_num = 4'hf;
        {exc_pc_fault, exc_pc_next} = {32'h0000_1234, 32'h0000_1236};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("cfg reset", 32'h0, core_config_word)
        `CHK("status reset", 16'h2700, processor_status_word)
        wr(0, 32'hffff_ffff);
        `CHK("cfg mask", 32'hea00_0000, core_config_word)
        `CHK("cfg bits", 5'h1f, cb)
        wr(2, 32'h1234_5678);
        `CHK("base align", 32'h0030_0000, vector_base)
        wr(1, 32'hffff);
        `CHK("status mask", 16'hb71f, processor_status_word)
        wr(1, 32'h2500);
        wr(3, 32'h2300);
        `CHK("saved mask", 3'd5, sl_saved_mask)
        `CHK("loaded status", 16'h2300, processor_status_word)
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 15; k++)
                if (k != 13 && !(k == 14 && c[1]))
                begin
                    wr(0, {c[1:0], 30'h0});
                    `CHK("cfg bits", {c[1:0], 3'b000}, cb)
                    wr(1, 32'h8700);
                    fault(k, {c[1:0], 30'h0}, 32'h2000 + k, fsc[(k + c) % 4]);
                end
        irq(1'b1);
        irq(1'b0);
        final_report();
    end
endmodule : testbench
